// *** rtl/cap_desc_map.svh ***
// register offsets, field positions, reset values and descriptor layout of the capability page
// Contract
// - signature is four bytes; two matching means valid
// - repeat page at 256 and 512, more allowed
// - vendor revision at 164-165, vendor area 166-253
// - byte 162 flags ddr2 modes 8-10, rest zero
// - timing field bit0 modes 0-3, bits1-4 modes 4-7
// - revision bit0 zero, bits 1-11 revisions, 12-15 zero
// - features bit0 sets bus width; ddr forces 8-bit
// - some commands always transfer eight bits wide
// - ddr interface bits need timing fields filled
// - bit3 multi-plane program/erase, bit6 multi-plane read
// - bit7 extended page; clear in managed ecc mode
// - bit8 per-lun page register clear on program
// - power-up clears every lun page register
// - bit9 managed ecc mode, clear means raw
// - bits 11,12,14,15 extra capabilities flags
`ifndef CAP_DESC_MAP_SVH
`define CAP_DESC_MAP_SVH

// wishbone register byte addresses
`define REG_CTRL 8'h00
`define REG_FEAT 8'h04
`define REG_REV 8'h08
`define REG_TIMING 8'h0c
`define REG_VENDOR_REV 8'h10
`define REG_LUN_CLR 8'h14
`define REG_STATUS 8'h18
`define REG_RD_ADDR 8'h1c
`define REG_RD_DATA 8'h20

// descriptor byte positions
`define DESC_SIG0 8'h00
`define DESC_SIG3 8'h03
`define DESC_REV_LO 8'h04
`define DESC_REV_HI 8'h05
`define DESC_FEAT_LO 8'h06
`define DESC_FEAT_HI 8'h07
`define DESC_DDR_TM 8'h8d
`define DESC_DDR2_TM_LO 8'h8e
`define DESC_DDR3_TM_LO 8'ha0
`define DESC_DDR3_TM_HI 8'ha1
`define DESC_DDR2_TM_HI 8'ha2
`define DESC_VREV_LO 8'ha4
`define DESC_VREV_HI 8'ha5
`define DESC_VEND_FIRST 8'ha6
`define DESC_VEND_LAST 8'hfd
`define DESC_CRC_LO 8'hfe
`define DESC_CRC_HI 8'hff
`define DESC_COPIES 3

// feature bit positions
`define FEAT_X16 0
`define FEAT_MULTI_LUN 1
`define FEAT_NONSEQ_PROG 2
`define FEAT_MP_PROG 3
`define FEAT_COPYBACK_ANY 4
`define FEAT_DDR 5
`define FEAT_MP_READ 6
`define FEAT_EXT_PAGE 7
`define FEAT_LUN_CLR 8
`define FEAT_MANAGED_ECC 9
`define FEAT_DDR2 10
`define FEAT_VOLUME 11
`define FEAT_VPP 12
`define FEAT_DDR3 13
`define FEAT_ZQ 14
`define FEAT_PAD_CAP 15

// reset values
`define FEAT_RST 16'h0000
`define REV_RST 16'h0800
`define TIMING_RST 32'h0000_0001
`define VREV_RST 16'h0001
`define CRC_RST 16'h0000
`define LUN_MASK_RST 8'h00

`endif

// *** rtl/cap_desc_pkg.sv ***
// types shared by the capability descriptor block
package cap_desc_pkg;

    // classic wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    // wishbone answer to the master
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] dat;
    } wb_rsp_t;

    // page serving state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STREAM = 2'b01,
        ST_DONE = 2'b11
    } page_state_t;

    // feature word presented to the rest of the target
    typedef struct packed {
        logic x16;
        logic multi_lun;
        logic nonseq_prog;
        logic copyback_any;
        logic managed_ecc;
        logic lun_clr_one;
    } feat_view_t;

endpackage

// *** rtl/cap_desc.sv ***
// capability descriptor page source with wishbone configuration
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cap_desc_map.svh"

module cap_desc
    import cap_desc_pkg::*;
#(
    parameter int LUNS = 4,
    parameter logic [15:0] SIG_WORD_LO = 16'h1234, // arbitrary signature value
    parameter logic [15:0] SIG_WORD_HI = 16'h5678 // arbitrary signature value
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire wb_req_t wb_req,
    output var wb_rsp_t wb_rsp,
    input wire logic page_start,
    input wire logic page_next,
    input wire logic prog_cmd,
    input wire logic [7:0] prog_lun,
    output logic [7:0] page_byte,
    output logic page_valid,
    output logic [LUNS-1:0] page_reg_clear,
    output var feat_view_t feat_view
);

    typedef struct packed {
        wb_rsp_t rsp;
        logic [15:0] feat;
        logic [15:0] rev;
        logic [31:0] timing;
        logic [15:0] vrev;
        logic [15:0] crc;
        logic [7:0] rd_addr;
        logic [7:0] vend_byte;
        page_state_t st;
        logic [9:0] pos;
        logic [7:0] byte_q;
        logic vld;
        logic [LUNS-1:0] clr;
        logic boot;
        feat_view_t view;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    // sanitise the feature word as software writes it
    function automatic logic [15:0] clean_feat(input logic [15:0] f);
        logic [15:0] r;
        r = f;
        if (r[`FEAT_DDR] | r[`FEAT_DDR2] | r[`FEAT_DDR3])
        begin
            r[`FEAT_X16] = 1'b0;
        end
        if (r[`FEAT_MANAGED_ECC])
        begin
            r[`FEAT_EXT_PAGE] = 1'b0;
        end
        return r;
    endfunction

    // descriptor byte at an in-page offset
    function automatic logic [7:0] desc_byte(input state_t s, input logic [7:0] a);
        logic [7:0] b;
        b = 8'h00;
        unique case (a)
            8'h00: b = SIG_WORD_LO[7:0];
            8'h01: b = SIG_WORD_LO[15:8];
            8'h02: b = SIG_WORD_HI[7:0];
            `DESC_SIG3: b = SIG_WORD_HI[15:8];
            `DESC_REV_LO: b = {s.rev[7:1], 1'b0};
            `DESC_REV_HI: b = {4'h0, s.rev[11:8]};
            `DESC_FEAT_LO: b = s.feat[7:0];
            `DESC_FEAT_HI: b = s.feat[15:8];
            `DESC_DDR_TM: b = s.feat[`FEAT_DDR] ? s.timing[7:0] : 8'h00;
            `DESC_DDR2_TM_LO: b = s.feat[`FEAT_DDR2] ? s.timing[15:8] : 8'h00;
            `DESC_DDR3_TM_LO: b = s.feat[`FEAT_DDR3] ? {3'h0, s.timing[20:16]} : 8'h00;
            `DESC_DDR2_TM_HI: b = s.feat[`FEAT_DDR2] ? {5'h00, s.timing[26:24]} : 8'h00;
            `DESC_VREV_LO: b = s.vrev[7:0];
            `DESC_VREV_HI: b = s.vrev[15:8];
            `DESC_CRC_LO: b = s.crc[7:0];
            `DESC_CRC_HI: b = s.crc[15:8];
            default:
            begin
                if (a >= `DESC_VEND_FIRST && a <= `DESC_VEND_LAST)
                begin
                    b = s.vend_byte;
                end
            end
        endcase
        return b;
    endfunction

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input wb_req_t q);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (q.sel[i])
            begin
                r[i*8 +: 8] = q.dat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // next-state logic: bus slave, page streaming and page register clears
    always_comb
    begin
        logic [31:0] w;
        logic [31:0] m;
        logic hit;
        logic [9:0] last_pos;
        w = 32'h0;
        m = 32'h0;
        hit = 1'b1;
        last_pos = 10'((`DESC_COPIES * 256) - 1);
        nxt_ff = cur_ff;
        nxt_ff.rsp.ack = 1'b0;
        nxt_ff.rsp.err = 1'b0;
        nxt_ff.clr = '0;
        nxt_ff.boot = 1'b0;
        // power-up clears every lun page register
        if (cur_ff.boot)
        begin
            nxt_ff.clr = '1;
        end
        else if (prog_cmd)
        begin
            if (cur_ff.feat[`FEAT_LUN_CLR])
            begin
                for (int i = 0; i < LUNS; i++)
                begin
                    nxt_ff.clr[i] = (prog_lun == 8'(i));
                end
            end
            else
            begin
                nxt_ff.clr = '1;
            end
        end
        // wishbone slave, one wait state then ack, or err for an unmapped address
        if (wb_req.cyc && wb_req.stb && !cur_ff.rsp.ack && !cur_ff.rsp.err)
        begin
            unique case (wb_req.adr)
                `REG_CTRL: w = {30'h0, cur_ff.vld, cur_ff.st == ST_DONE};
                `REG_FEAT: w = {16'h0, cur_ff.feat};
                `REG_REV: w = {16'h0, cur_ff.rev};
                `REG_TIMING: w = cur_ff.timing;
                `REG_VENDOR_REV: w = {cur_ff.crc, cur_ff.vrev};
                `REG_LUN_CLR: w = {24'h0, cur_ff.vend_byte};
                `REG_STATUS: w = {20'h0, 2'(cur_ff.st), cur_ff.pos};
                `REG_RD_ADDR: w = {24'h0, cur_ff.rd_addr};
                `REG_RD_DATA: w = {24'h0, desc_byte(cur_ff, cur_ff.rd_addr)};
                default: hit = 1'b0;
            endcase
            nxt_ff.rsp.dat = hit ? w : 32'h0;
            nxt_ff.rsp.ack = hit;
            nxt_ff.rsp.err = !hit;
            if (hit && wb_req.we)
            begin
                // merge the written lanes into the word the read path selected
                m = lane_merge(w, wb_req);
                unique case (wb_req.adr)
                    `REG_FEAT: nxt_ff.feat = clean_feat(m[15:0]);
                    `REG_REV: nxt_ff.rev = m[15:0] & 16'h0ffe;
                    `REG_TIMING: nxt_ff.timing = m & 32'h071f_ffff;
                    `REG_VENDOR_REV: {nxt_ff.crc, nxt_ff.vrev} = m;
                    `REG_LUN_CLR: nxt_ff.vend_byte = m[7:0];
                    `REG_RD_ADDR: nxt_ff.rd_addr = m[7:0];
                    default: nxt_ff.rd_addr = cur_ff.rd_addr;
                endcase
            end
        end
        // page streaming across the primary and redundant copies
        unique case (cur_ff.st)
            ST_IDLE:
            begin
                nxt_ff.vld = 1'b0;
                if (page_start)
                begin
                    nxt_ff.st = ST_STREAM;
                    nxt_ff.pos = 10'h000;
                    nxt_ff.byte_q = desc_byte(cur_ff, 8'h00);
                    nxt_ff.vld = 1'b1;
                end
            end
            ST_STREAM:
            begin
                if (page_next)
                begin
                    if (cur_ff.pos == last_pos)
                    begin
                        nxt_ff.st = ST_DONE;
                        nxt_ff.vld = 1'b0;
                    end
                    else
                    begin
                        nxt_ff.pos = cur_ff.pos + 10'h001;
                        // bytes leave eight bits wide whatever bus width is reported
                        nxt_ff.byte_q = desc_byte(cur_ff, 8'(cur_ff.pos + 10'h001));
                    end
                end
            end
            ST_DONE:
            begin
                nxt_ff.vld = 1'b0;
                nxt_ff.byte_q = 8'h00;
                if (page_start)
                begin
                    nxt_ff.st = ST_STREAM;
                    nxt_ff.pos = 10'h000;
                    nxt_ff.byte_q = desc_byte(cur_ff, 8'h00);
                    nxt_ff.vld = 1'b1;
                end
            end
            default:
            begin
                nxt_ff.st = ST_IDLE;
            end
        endcase
        // live feature view for the rest of the target
        nxt_ff.view.x16 = cur_ff.feat[`FEAT_X16];
        nxt_ff.view.multi_lun = cur_ff.feat[`FEAT_MULTI_LUN];
        nxt_ff.view.nonseq_prog = cur_ff.feat[`FEAT_NONSEQ_PROG];
        nxt_ff.view.copyback_any = cur_ff.feat[`FEAT_COPYBACK_ANY];
        nxt_ff.view.managed_ecc = cur_ff.feat[`FEAT_MANAGED_ECC];
        nxt_ff.view.lun_clr_one = cur_ff.feat[`FEAT_LUN_CLR];
    end

    // state register
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cur_ff <= '0;
            cur_ff.feat <= `FEAT_RST;
            cur_ff.rev <= `REV_RST;
            cur_ff.timing <= `TIMING_RST;
            cur_ff.vrev <= `VREV_RST;
            cur_ff.crc <= `CRC_RST;
            cur_ff.st <= ST_IDLE;
            cur_ff.boot <= 1'b1;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    assign wb_rsp = cur_ff.rsp;
    assign page_byte = cur_ff.byte_q;
    assign page_valid = cur_ff.vld;
    assign page_reg_clear = cur_ff.clr;
    assign feat_view = cur_ff.view;

endmodule
`default_nettype wire

// *** testbench/cap_desc_checker.sv ***
// concurrent checks on the capability descriptor ports
`timescale 1ns/1ps
`default_nettype none
`include "cap_desc_map.svh"

module cap_desc_checker
    import cap_desc_pkg::*;
#(
    parameter int LUNS = 4
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire wb_req_t wb_req,
    input wire wb_rsp_t wb_rsp,
    input wire logic page_start,
    input wire logic page_next,
    input wire logic prog_cmd,
    input wire logic [7:0] prog_lun,
    input wire logic [7:0] page_byte,
    input wire logic page_valid,
    input wire logic [LUNS-1:0] page_reg_clear,
    input wire feat_view_t feat_view
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // read answer, with the request still held on the bus
    logic rd_ack;
    assign rd_ack = wb_rsp.ack && !wb_req.we;

    a_answer_next: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack && !wb_rsp.err
        |=> wb_rsp.ack || wb_rsp.err) else $error("no answer one cycle after request");
    a_rev_reserved: assert property (rd_ack && wb_req.adr == `REG_REV
        |-> wb_rsp.dat[0] == 1'b0 && wb_rsp.dat[15:12] == 4'h0) else $error("revision bits");
    a_timing_reserved: assert property (rd_ack && wb_req.adr == `REG_TIMING
        |-> (wb_rsp.dat & ~32'h071f_ffff) == 32'h0) else $error("timing reserved bits");
    a_ddr_width: assert property (rd_ack && wb_req.adr == `REG_FEAT
        && (wb_rsp.dat[5] || wb_rsp.dat[10] || wb_rsp.dat[13]) |-> !wb_rsp.dat[0])
        else $error("wide bus with ddr");
    a_ext_page_ecc: assert property (rd_ack && wb_req.adr == `REG_FEAT
        && wb_rsp.dat[9] |-> !wb_rsp.dat[7]) else $error("extended page with managed ecc");
    a_clear_one_lun: assert property (prog_cmd && feat_view.lun_clr_one
        && $stable(feat_view.lun_clr_one) && prog_lun < LUNS
        |=> page_reg_clear == (LUNS'(1) << prog_lun)) else $error("single lun clear");
    a_clear_all_lun: assert property (prog_cmd && !feat_view.lun_clr_one
        && $stable(feat_view.lun_clr_one) |=> &page_reg_clear) else $error("all lun clear");
    a_power_clear: assert property ($rose(rstn)
        |-> ##[1:2] &page_reg_clear) else $error("no power-up clear");
    a_byte_holds: assert property (page_valid && !page_next
        |=> $stable(page_byte)) else $error("page byte moved");

    c_unmapped: cover property (wb_rsp.err);
    c_feat_read: cover property (rd_ack && wb_req.adr == `REG_FEAT);
    c_page_end: cover property ($fell(page_valid));
endmodule

bind cap_desc cap_desc_checker #(.LUNS(LUNS)) cap_desc_checker_i (
    .clock(clock),
    .rstn(rstn),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp),
    .page_start(page_start),
    .page_next(page_next),
    .prog_cmd(prog_cmd),
    .prog_lun(prog_lun),
    .page_byte(page_byte),
    .page_valid(page_valid),
    .page_reg_clear(page_reg_clear),
    .feat_view(feat_view)
);
`default_nettype wire

// *** testbench/cap_desc_host.sv ***
// host-side model that fetches and decodes the descriptor page
`timescale 1ns/1ps
`default_nettype none

module cap_desc_host (
    input wire logic clock,
    input wire logic page_valid,
    input wire logic [7:0] page_byte,
    output logic page_start,
    output logic page_next,
    output logic sig_ok,
    output logic copies_ok,
    output logic [15:0] feat
);
    logic [7:0] copy0 [256];

    initial
    begin
        page_start = 1'b0;
        page_next = 1'b0;
    end

    // walk all copies, slowly if asked, and decode the first one
    task automatic read_page(input logic slow, input logic [31:0] sig);
        int i;
        int hits [3];
        hits = '{0, 0, 0};
        copies_ok = 1'b1;
        page_start <= 1'b1;
        @(posedge clock);
        page_start <= 1'b0;
        for (i = 0; i < 768; i++)
        begin
            @(posedge clock);
            if (slow)
                @(posedge clock);
            if (page_valid !== 1'b1)
                copies_ok = 1'b0;
            if (i % 256 < 4 && page_byte === sig[8*(i % 256) +: 8])
                hits[i / 256]++;
            if (i < 256)
                copy0[i] = page_byte;
            else if (page_byte !== copy0[i % 256])
                copies_ok = 1'b0;
            page_next <= 1'b1;
            @(posedge clock);
            page_next <= 1'b0;
        end
        // every copy must pass, so that each can stand in for the one before
        sig_ok = (hits[0] >= 2) && (hits[1] >= 2) && (hits[2] >= 2);
        feat = {copy0[7], copy0[6]};
    endtask
endmodule
`default_nettype wire

// *** testbench/cap_desc_tb_top.sv ***
// bench for the capability descriptor block
`timescale 1ns/1ps
`default_nettype none
`include "cap_desc_map.svh"

module cap_desc_tb_top
    import cap_desc_pkg::*;
;
    logic clock;
    logic rstn;
    wb_req_t wb_req;
    wb_rsp_t wb_rsp;
    logic page_start;
    logic page_next;
    logic prog_cmd;
    logic [7:0] prog_lun;
    logic [7:0] page_byte;
    logic page_valid;
    logic [3:0] page_reg_clear;
    feat_view_t feat_view;
    logic sig_ok;
    logic copies_ok;
    logic [15:0] feat;
    logic pwr_clr = 1'b0;
    logic [31:0] q;
    logic q_err;
    int n_errors;
    int n_tests;

    // signature words are arbitrary, equal bytes so byte order does not matter
    cap_desc #(.LUNS(4), .SIG_WORD_LO(16'h6b6b), .SIG_WORD_HI(16'h6b6b)) cap_desc_i (
        .clock(clock),
        .rstn(rstn),
        .wb_req(wb_req),
        .wb_rsp(wb_rsp),
        .page_start(page_start),
        .page_next(page_next),
        .prog_cmd(prog_cmd),
        .prog_lun(prog_lun),
        .page_byte(page_byte),
        .page_valid(page_valid),
        .page_reg_clear(page_reg_clear),
        .feat_view(feat_view)
    );

    cap_desc_host cap_desc_host_i (
        .clock(clock),
        .page_valid(page_valid),
        .page_byte(page_byte),
        .page_start(page_start),
        .page_next(page_next),
        .sig_ok(sig_ok),
        .copies_ok(copies_ok),
        .feat(feat)
    );

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // remember that every lun was cleared at some edge
    always @(posedge clock)
        if (page_reg_clear === 4'hf)
            pwr_clr <= 1'b1;

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle, held until ack or err, then one idle cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        for (k = 0; k < 20; k++)
        begin
            @(posedge clock);
            if (wb_rsp.ack || wb_rsp.err)
                break;
        end
        q = wb_rsp.dat;
        q_err = wb_rsp.err;
        wb_req <= '0;
        if (k == 20)
        begin
            n_errors++;
            test_done();
        end
        @(posedge clock);
    endtask

    task automatic desc(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b1, `REG_RD_ADDR, {24'h0, a});
        wb(1'b0, `REG_RD_DATA, 32'h0);
        chk("descriptor byte", {24'h0, exp}, {24'h0, q[7:0]});
    endtask

    task automatic t_reset();
        chk("power-up clear", 32'h1, {31'h0, pwr_clr});
        wb(1'b0, `REG_FEAT, 32'h0);
        chk("feat reset", {16'h0, `FEAT_RST}, {16'h0, q[15:0]});
        wb(1'b0, `REG_REV, 32'h0);
        chk("rev reset", {16'h0, `REV_RST}, {16'h0, q[15:0]});
        wb(1'b0, `REG_TIMING, 32'h0);
        chk("timing reset", `TIMING_RST, q);
        $display("test reset done");
    endtask

    task automatic t_fields();
        wb(1'b1, `REG_FEAT, 32'hffff);
        wb(1'b0, `REG_FEAT, 32'h0);
        chk("feat masked", 32'hff7e, {16'h0, q[15:0]});
        wb(1'b1, `REG_REV, 32'hffff_ffff);
        wb(1'b0, `REG_REV, 32'h0);
        chk("rev masked", 32'h0ffe, {16'h0, q[15:0]});
        wb(1'b1, `REG_TIMING, 32'hffff_ffff);
        wb(1'b0, `REG_TIMING, 32'h0);
        chk("timing masked", 32'h071f_ffff, q);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, q_err});
        chk("feat view", 32'h1f, {26'h0, feat_view});
        $display("test fields done");
    endtask

    task automatic t_bytes();
        wb(1'b1, `REG_VENDOR_REV, 32'habcd_1357);
        desc(`DESC_VREV_LO, 8'h57);
        desc(`DESC_VREV_HI, 8'h13);
        desc(`DESC_DDR2_TM_HI, 8'h07);
        desc(`DESC_REV_LO, 8'hfe);
        desc(`DESC_FEAT_HI, 8'hff);
        $display("test bytes done");
    endtask

    task automatic t_page(input logic slow, input logic [15:0] ef);
        cap_desc_host_i.read_page(slow, 32'h6b6b_6b6b);
        @(posedge clock);
        chk("signature", 32'h1, {31'h0, sig_ok});
        chk("copies", 32'h1, {31'h0, copies_ok});
        chk("page feat", {16'h0, ef}, {16'h0, feat});
        chk("page end", 32'h0, {31'h0, page_valid});
        wb(1'b0, `REG_CTRL, 32'h0);
        chk("page done", 32'h1, q);
        $display("test page done");
    endtask

    // wide bus reported, page still streams byte by byte
    task automatic t_wide();
        wb(1'b1, `REG_FEAT, 32'h0001);
        chk("x16 view", 32'h20, {26'h0, feat_view});
        t_page(1'b0, 16'h0001);
        $display("test wide done");
    endtask

    task automatic t_lun(input logic [31:0] f, input logic [7:0] l, input logic [3:0] exp);
        wb(1'b1, `REG_FEAT, f);
        repeat (3) @(posedge clock);
        prog_lun <= l;
        prog_cmd <= 1'b1;
        @(posedge clock);
        prog_cmd <= 1'b0;
        @(posedge clock);
        chk("lun clear", {28'h0, exp}, {28'h0, page_reg_clear});
        $display("test lun done");
    endtask

    initial
    begin
        n_errors = 0;
        n_tests = 0;
        rstn = 1'b0;
        wb_req = '0;
        prog_cmd = 1'b0;
        prog_lun = 8'h0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        repeat (3) @(posedge clock);
        t_reset();
        t_fields();
        t_bytes();
        t_page(1'b0, 16'hff7e);
        t_page(1'b1, 16'hff7e);
        t_wide();
        t_lun(32'h0100, 8'h2, 4'h4);
        t_lun(32'h0000, 8'h3, 4'hf);
        test_done();
    end
endmodule
`default_nettype wire
